/* verilog/adc_serial_pkg.sv */
// Purpose: Shared constants and types for the converter serial result port.
// Assumes: 32-bit classic Wishbone register bus, 16-bit result words.
// Notes:   Register offsets are byte addresses, one aligned word each.
package adc_serial_pkg;

  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [15:0] MSB_FLIP = 16'h8000;

  localparam int unsigned WB_ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [31:0] WB_ZERO = 32'h0000_0000;

  localparam int unsigned CTRL_W = 4;
  localparam int CTRL_SERIAL = 0;
  localparam int CTRL_CLK_SRC = 1;
  localparam int CTRL_CLK_INV = 2;
  localparam int CTRL_FORMAT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  localparam int ST_VALID = 0;
  localparam int ST_WAIT = 1;
  localparam int ST_SHIFT = 2;
  localparam int ST_LINK_BUSY = 3;
  localparam int ST_READ_MODE = 4;

  localparam int PIN_CHAIN = 7;
  localparam int PIN_SDO = 8;
  localparam int PIN_SCLK = 9;

  // Reference cycles per internal serial clock period
  localparam int unsigned SCLK_PHASES_DEF = 4;

  typedef enum logic [1:0]
  {
    M_IDLE = 2'b00,
    M_WAIT = 2'b01,
    M_SHIFT = 2'b10
  } mst_state_e;

  function automatic logic [WORD_BITS-1:0] fmt_word(input logic [WORD_BITS-1:0] raw,
                                                    input logic straight);
    fmt_word = straight ? raw : (raw ^ MSB_FLIP);
  endfunction : fmt_word

endpackage : adc_serial_pkg

/* verilog/link_if.sv */
// Purpose: Carrier between the reference-clock core and the link-clock shifter.
// Assumes: word and invert are held stable while a link transfer is in flight.
// Notes:   load_tog and done_tog are toggles; each crosses through two flops.
`timescale 1ns/1ns
interface link_if;
  import adc_serial_pkg::*;
  logic [WORD_BITS-1:0] word;
  logic load_tog;
  logic invert;
  logic chain_in;
  logic done_tog;
  logic serial_data;

  modport ref_side (output word, output load_tog, output invert, output chain_in,
                    input done_tog, input serial_data);
  modport link_side (input word, input load_tog, input invert, input chain_in,
                     output done_tog, output serial_data);
endinterface : link_if

/* verilog/serial_link_shifter.sv */
// Purpose: Slave-mode shifter running on the host-supplied serial clock.
// Assumes: invert only changes while no transfer is running.
// Notes:   Clock polarity is picked by an XOR in the clock path.
`timescale 1ns/1ns
module serial_link_shifter
  import adc_serial_pkg::*;
(
  input wire logic i_link_sclk,
  input wire logic i_reset_n,
  link_if.link_side lnk
);

  wire shift_clk;
  wire load_now;
  logic rst_s1_q;
  logic rst_s2_q;
  logic load_s1_q;
  logic load_s2_q;
  logic seen_q;
  logic done_q;
  logic armed_q;
  logic [WORD_BITS-1:0] shreg_q;
  logic [CNT_W-1:0] cnt_q;

  // Update edge is the rising edge, or the falling one when inverted
  assign shift_clk = i_link_sclk ^ lnk.invert;
  assign load_now = (load_s2_q != seen_q);
  assign lnk.serial_data = shreg_q[WORD_BITS-1];
  assign lnk.done_tog = done_q;

  always_ff @(posedge shift_clk)
  begin
    rst_s1_q <= i_reset_n;
    rst_s2_q <= rst_s1_q;
    load_s1_q <= lnk.load_tog;
    load_s2_q <= load_s1_q;
  end

  always_ff @(posedge shift_clk)
  begin
    if (!rst_s2_q)
    begin
      seen_q <= 1'b0;
      done_q <= 1'b0;
      armed_q <= 1'b0;
      shreg_q <= '0;
      // Count rests at full, so a host clocking an idle port never reports a word done
      cnt_q <= CNT_FULL;
    end
    else if (load_now)
    begin
      seen_q <= load_s2_q;
      armed_q <= 1'b1;
      shreg_q <= lnk.word;
      cnt_q <= '0;
    end
    else
    begin
      // Chain input follows the word, MSB first
      shreg_q <= {shreg_q[WORD_BITS-2:0], lnk.chain_in};
      if (cnt_q != CNT_FULL)
      begin
        cnt_q <= cnt_q + 5'h01;
      end
      if (cnt_q == (CNT_FULL - 5'h01))
      begin
        done_q <= ~done_q;
      end
    end
  end

  property p_link_msb_first;
    @(posedge shift_clk) disable iff (!rst_s2_q)
    load_now |=> (lnk.serial_data == $past(lnk.word[WORD_BITS-1]));
  endproperty
  a_link_msb_first: assert property (p_link_msb_first)
    else $error("Slave shifter did not present the MSB after loading");

  property p_chain_delay;
    @(posedge shift_clk) disable iff (!rst_s2_q)
    (armed_q && (cnt_q == CNT_FULL)) |-> (lnk.serial_data == $past(lnk.chain_in, 16));
  endproperty
  a_chain_delay: assert property (p_chain_delay)
    else $error("Chain input not passed through after sixteen periods");

endmodule : serial_link_shifter

/* verilog/adc_serial_result_port.sv */
// Purpose: Serial result port of a 16-bit sampling converter, shared with parallel bits.
// Assumes: Result, busy and read request come from same-clock converter logic.
// Notes:   Mode bits other than read mode live in a Wishbone control register instead of pins.
`timescale 1ns/1ns
module adc_serial_result_port
  import adc_serial_pkg::*;
#(
  parameter int unsigned SCLK_PHASES = SCLK_PHASES_DEF
)
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_SERIAL_CLOCK,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [WB_ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic [WORD_BITS-1:0] I_RESULT,
  input wire logic I_RESULT_LOAD,
  input wire logic I_CONV_BUSY,
  input wire logic I_READ_REQ,
  input wire logic I_READ_MODE_OR_CHAIN_INPUT,
  output logic [WORD_BITS-1:0] O_DATA,
  output logic O_PARALLEL_BIT_SEVEN_OE_N,
  output logic O_PARALLEL_BIT_NINE_OE_N
);

  localparam int unsigned PH_W = $clog2(SCLK_PHASES);
  localparam logic [PH_W-1:0] PH_UPDATE = PH_W'(0);
  localparam logic [PH_W-1:0] PH_RISE = PH_W'(1);
  localparam logic [PH_W-1:0] PH_FALL = PH_W'(1 + SCLK_PHASES / 2);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(SCLK_PHASES - 1);
  localparam logic [15:0] SHIFT_CYCLES = 16'(WORD_BITS * SCLK_PHASES);

  link_if lnk();

  logic [CTRL_W-1:0] ctrl_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic rdc_s1_q;
  logic rdc_s2_q;
  logic done_s1_q;
  logic done_s2_q;
  logic [WORD_BITS-1:0] result_q;
  logic valid_q;
  logic [WORD_BITS-1:0] word_q;
  logic load_tog_q;
  mst_state_e mst_state_q;
  logic [PH_W-1:0] ph_q;
  logic [3:0] bit_q;
  logic [WORD_BITS-1:0] shreg_q;
  logic sdo_q;
  logic sclk_q;
  logic [WORD_BITS-1:0] data_q;
  logic oe7_n_q;
  logic oe9_n_q;
  logic [15:0] act_len_q;

  wire ser_mode;
  wire ext_clk;
  wire clk_inv;
  wire straight;
  wire link_busy;
  wire read_take;
  wire ext_take;
  wire int_take;
  wire mst_go;
  wire shifting;
  wire ph_last;
  wire bit_last;
  wire wb_req;
  wire wb_wr_ctrl;
  wire [31:0] status_w;
  wire [31:0] rd_mux;
  wire [WORD_BITS-1:0] par_word;
  wire [WORD_BITS-1:0] data_d;
  wire sclk_pin;

  // Mode decode from the control register
  assign ser_mode = ctrl_q[CTRL_SERIAL];
  assign ext_clk = ctrl_q[CTRL_CLK_SRC];
  assign clk_inv = ctrl_q[CTRL_CLK_INV];
  assign straight = ctrl_q[CTRL_FORMAT];

  // Register bus: one wait state, ack drops the cycle after it is given;
  // a write lands only at the edge where the master sees ack
  assign wb_req = I_WB_CYC & I_WB_STB & ~ack_q;
  assign wb_wr_ctrl = I_WB_CYC & I_WB_STB & ack_q & I_WB_WE & (I_WB_ADR == REG_CTRL) &
                      I_WB_SEL[0];
  assign status_w = {27'h0, rdc_s2_q, link_busy, shifting,
                     (mst_state_q == M_WAIT), valid_q};
  assign rd_mux = (I_WB_ADR == REG_CTRL) ? {28'h0000000, ctrl_q} :
                  (I_WB_ADR == REG_STATUS) ? status_w :
                  (I_WB_ADR == REG_RESULT) ? {16'h0000, result_q} : WB_ZERO;

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      ack_q <= 1'b0;
      dat_q <= WB_ZERO;
      ctrl_q <= CTRL_RESET;
    end
    else
    begin
      ack_q <= wb_req;
      dat_q <= (wb_req & ~I_WB_WE) ? rd_mux : WB_ZERO;
      if (wb_wr_ctrl)
      begin
        ctrl_q <= I_WB_DAT[CTRL_W-1:0];
      end
    end
  end

  // Pin and link toggle synchronisers
  always_ff @(posedge I_REF_CLK)
  begin
    rdc_s1_q <= I_READ_MODE_OR_CHAIN_INPUT;
    rdc_s2_q <= rdc_s1_q;
    done_s1_q <= lnk.done_tog;
    done_s2_q <= done_s1_q;
  end

  // Result store and read start; a busy port ignores new reads
  assign link_busy = (load_tog_q != done_s2_q);
  assign read_take = I_READ_REQ & ser_mode & valid_q;
  assign ext_take = read_take & ext_clk & ~link_busy;
  assign int_take = read_take & ~ext_clk & (mst_state_q == M_IDLE);

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      result_q <= '0;
      valid_q <= 1'b0;
      word_q <= '0;
      load_tog_q <= 1'b0;
    end
    else
    begin
      if (I_RESULT_LOAD)
      begin
        result_q <= I_RESULT;
        valid_q <= 1'b1;
      end
      // Word is frozen here so a new result cannot disturb a read
      if (ext_take | int_take)
      begin
        word_q <= fmt_word(result_q, straight);
      end
      if (ext_take)
      begin
        load_tog_q <= ~load_tog_q;
      end
    end
  end

  assign lnk.word = word_q;
  assign lnk.load_tog = load_tog_q;
  assign lnk.invert = clk_inv;
  assign lnk.chain_in = I_READ_MODE_OR_CHAIN_INPUT;

  serial_link_shifter serial_link_shifter_i
  (
    .i_link_sclk(I_SERIAL_CLOCK),
    .i_reset_n(I_RESET_N),
    .lnk(lnk)
  );

  // Internal-clock master: read mode decides whether to wait out conversion
  assign mst_go = rdc_s2_q | ~I_CONV_BUSY;
  assign shifting = (mst_state_q == M_SHIFT);
  assign ph_last = (ph_q == PH_LAST);
  assign bit_last = (bit_q == BIT_LAST);

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      mst_state_q <= M_IDLE;
    end
    else
    begin
      unique case (mst_state_q)
        M_IDLE:
        begin
          if (int_take)
          begin
            mst_state_q <= M_WAIT;
          end
        end
        M_WAIT:
        begin
          if (mst_go)
          begin
            mst_state_q <= M_SHIFT;
          end
        end
        M_SHIFT:
        begin
          if (ph_last & bit_last)
          begin
            mst_state_q <= M_IDLE;
          end
        end
        default:
        begin
          mst_state_q <= M_IDLE;
        end
      endcase
    end
  end

  // Data moves half way between a falling and a rising edge, so it is
  // stable at both clock edges
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      ph_q <= '0;
      bit_q <= '0;
      shreg_q <= '0;
      sdo_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else if ((mst_state_q == M_WAIT) & mst_go)
    begin
      shreg_q <= word_q;
      ph_q <= '0;
      bit_q <= '0;
    end
    else if (shifting)
    begin
      ph_q <= ph_last ? '0 : ph_q + PH_W'(1);
      if (ph_q == PH_UPDATE)
      begin
        sdo_q <= shreg_q[WORD_BITS-1];
        shreg_q <= {shreg_q[WORD_BITS-2:0], 1'b0};
      end
      if (ph_q == PH_RISE)
      begin
        sclk_q <= 1'b1;
      end
      if (ph_q == PH_FALL)
      begin
        sclk_q <= 1'b0;
      end
      if (ph_last)
      begin
        bit_q <= bit_q + 4'h1;
      end
    end
  end

  // Shared pin drive; bit 7 stays parallel data value but is released
  assign par_word = fmt_word(result_q, straight);
  assign sclk_pin = ext_clk ? 1'b0 : (sclk_q ^ clk_inv);
  assign data_d = ser_mode ?
                  {par_word[15:10], sclk_pin, sdo_q, par_word[7:0]} :
                  par_word;

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N)
    begin
      data_q <= '0;
      oe7_n_q <= 1'b0;
      oe9_n_q <= 1'b0;
    end
    else
    begin
      data_q <= data_d;
      oe7_n_q <= ser_mode;
      oe9_n_q <= ser_mode & ext_clk;
    end
  end

  // In slave mode the data pin must follow the host clock, so it is taken
  // straight from the link-side shift register
  assign O_DATA = {data_q[15:PIN_SDO+1],
                   (ser_mode & ext_clk) ? lnk.serial_data : data_q[PIN_SDO],
                   data_q[PIN_SDO-1:0]};
  assign O_PARALLEL_BIT_SEVEN_OE_N = oe7_n_q;
  assign O_PARALLEL_BIT_NINE_OE_N = oe9_n_q;
  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = dat_q;

  // Helper: length of a master shift burst
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESET_N | ~shifting)
    begin
      act_len_q <= '0;
    end
    else
    begin
      act_len_q <= act_len_q + 16'h0001;
    end
  end

  sequence s_mst_start;
    $rose(mst_state_q == M_SHIFT);
  endsequence

  sequence s_mst_end;
    $fell(mst_state_q == M_SHIFT);
  endsequence

  property p_parallel_drive;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    ($past(I_RESET_N) && !$past(ser_mode) && !ser_mode) |->
      (!O_PARALLEL_BIT_SEVEN_OE_N && !O_PARALLEL_BIT_NINE_OE_N &&
       O_DATA == $past(par_word));
  endproperty
  a_parallel_drive: assert property (p_parallel_drive)
    else $error("Parallel mode does not drive the full result word");

  property p_chain_pin_input;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    $past(ser_mode) |-> O_PARALLEL_BIT_SEVEN_OE_N;
  endproperty
  a_chain_pin_input: assert property (p_chain_pin_input)
    else $error("Shared input pin is driven in serial mode");

  property p_wait_conversion;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    s_mst_start |-> ($past(rdc_s2_q) || !$past(I_CONV_BUSY));
  endproperty
  a_wait_conversion: assert property (p_wait_conversion)
    else $error("Shifting began during conversion with read-after mode");

  property p_msb_first;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    s_mst_start ##1 1'b1 |-> (sdo_q == word_q[WORD_BITS-1]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("First internal-clock bit is not the MSB");

  property p_whole_word;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    s_mst_end |-> (act_len_q == SHIFT_CYCLES);
  endproperty
  a_whole_word: assert property (p_whole_word)
    else $error("Internal-clock burst length is not one whole word");

  property p_both_edges;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (shifting && $changed(sdo_q)) |-> ($stable(sclk_q) && !sclk_q);
  endproperty
  a_both_edges: assert property (p_both_edges)
    else $error("Serial data changed at a serial clock edge");

  property p_clock_direction;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    $past(ser_mode) |-> (O_PARALLEL_BIT_NINE_OE_N == $past(ext_clk));
  endproperty
  a_clock_direction: assert property (p_clock_direction)
    else $error("Serial clock pin direction does not follow clock source");

  property p_idle_polarity;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    $past(ser_mode && !ext_clk && !shifting && !sclk_q) |->
      (O_DATA[PIN_SCLK] == $past(clk_inv));
  endproperty
  a_idle_polarity: assert property (p_idle_polarity)
    else $error("Idle serial clock level ignores the invert setting");

  property p_twos_complement;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    ($past(I_RESET_N) && $past(!ser_mode && !straight)) |->
      (O_DATA[WORD_BITS-1] == ~$past(result_q[WORD_BITS-1]));
  endproperty
  a_twos_complement: assert property (p_twos_complement)
    else $error("MSB not inverted for two's complement coding");

endmodule : adc_serial_result_port

/* verification/host_serial_model.sv */
// Purpose: Host serial port model that clocks the converter in slave mode.
// Assumes: Clock stands still between frames at the level set by i_inv.
// Notes:   Data is sampled on the edge opposite the update edge.
`timescale 1ns/1ns
module host_serial_model
(
  input wire logic i_go,
  input wire logic i_inv,
  input wire logic [5:0] i_periods,
  input wire logic i_sdo,
  output logic o_sclk,
  output logic [31:0] o_capt,
  output logic o_done
);
  initial
  begin
    o_sclk = 1'b0;
    o_capt = 32'h0000_0000;
    o_done = 1'b0;
  end

  // Idle level equals invert, so the first edge of a frame is always an update edge
  always @(posedge i_go)
  begin
    o_done = 1'b0;
    o_sclk = i_inv;
    repeat (i_periods)
    begin
      #7 o_sclk = ~o_sclk; // Host supplies the clock
      #8 o_sclk = ~o_sclk;
      o_capt = {o_capt[30:0], i_sdo}; // Sampled opposite the update edge
    end
    o_done = 1'b1;
  end
endmodule : host_serial_model

/* verification/adc_serial_result_port_tb.sv */
// Purpose: Self-checking bench for the converter serial result port.
// Assumes: Wishbone classic master here; host model clocks slave frames.
// Notes:   Expected reads and frames are queued and compared by a monitor.
`timescale 1ns/1ns
module adc_serial_result_port_tb;
  import adc_serial_pkg::*;
  logic clk, rst_n, cyc, stb, we, ack, res_ld, busy, rreq, pin_in, oe7_n, oe9_n;
  logic sclk, go, inv, done, int_on, pv, ck, c;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, capt;
  logic [15:0] res, dout, r, sh;
  logic [5:0] per;
  logic [31:0] wb_q[$], int_q[$], lnk_q[$];
  int n_fail, cmp_count, cnt;

  adc_serial_result_port adc_serial_result_port_i
  (
    .I_REF_CLK(clk),
    .I_RESET_N(rst_n),
    .I_SERIAL_CLOCK(sclk),
    .I_WB_CYC(cyc),
    .I_WB_STB(stb),
    .I_WB_WE(we),
    .I_WB_ADR(adr),
    .I_WB_SEL(sel),
    .I_WB_DAT(wdat),
    .O_WB_DAT(rdat),
    .O_WB_ACK(ack),
    .I_RESULT(res),
    .I_RESULT_LOAD(res_ld),
    .I_CONV_BUSY(busy),
    .I_READ_REQ(rreq),
    .I_READ_MODE_OR_CHAIN_INPUT(pin_in),
    .O_DATA(dout),
    .O_PARALLEL_BIT_SEVEN_OE_N(oe7_n),
    .O_PARALLEL_BIT_NINE_OE_N(oe9_n)
  );

  host_serial_model host_serial_model_i
  (
    .i_go(go),
    .i_inv(inv),
    .i_periods(per),
    .i_sdo(dout[PIN_SDO]),
    .o_sclk(sclk),
    .o_capt(capt),
    .o_done(done)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    chk(wb_q.size() + int_q.size() + lnk_q.size(), 32'h0);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Waits on ack with no assumed latency; ack or the 50-cycle count limit ends it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 50)
      chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulse(input logic ld, input logic [15:0] v);
    res <= v;
    res_ld <= ld;
    rreq <= !ld;
    @(posedge clk);
    res_ld <= 1'b0;
    rreq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // Host clocks during reset so the link domain leaves reset cleanly
  task automatic link_rst();
    rst_n <= 1'b0;
    go <= 1'b1;
    repeat (20) @(posedge clk);
    go <= 1'b0;
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : link_rst

  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0)
      chk(rdat, wb_q.pop_front());
    ck = dout[PIN_SCLK] ^ inv;
    if (int_on && ck && !pv)
    begin
      sh = {sh[14:0], dout[PIN_SDO]};
      cnt++;
    end
    if (int_on && !ck && pv && cnt > 0)
      chk({31'h0, dout[PIN_SDO]}, {31'h0, sh[0]});
    if (cnt == 16)
    begin
      chk({16'h0, sh}, int_q.pop_front());
      cnt = 0;
      int_on <= 1'b0;
    end
    pv = ck;
  end

  // Reset frames carry no word, so only queued frames are compared
  always @(posedge done)
    if (lnk_q.size() > 0)
      chk({12'h0, capt[19:0]}, lnk_q.pop_front());

  initial
  begin
    #200000;
    chk(32'h0, 32'h1);
    finish_test();
  end

  initial
  begin
    {rst_n, cyc, stb, we, res_ld, busy, rreq, pin_in, go, inv, int_on, pv} = 12'h000;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    res = 16'h0;
    per = 6'h04;
    n_fail = 0;
    cmp_count = 0;
    cnt = 0;
    void'($urandom(51437));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    link_rst();
    for (int f = 0; f < 2; f++)
    begin
      r = $urandom();
      wb(1'b1, REG_CTRL, {28'h0, f[0], 3'h0});
      pulse(1'b1, r);
      chk({16'h0, dout}, {16'h0, f[0] ? r : r ^ MSB_FLIP});
      chk({30'h0, oe7_n, oe9_n}, 32'h0);
      rd(REG_RESULT, {16'h0, r});
    end
    rd(8'h0C, 32'h0);
    rd(REG_CTRL, 32'h8);
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom();
      pulse(1'b1, r);
      wb(1'b1, REG_CTRL, {28'h0, k[1], k[0], 2'b01});
      inv <= k[0];
      repeat (3) @(posedge clk);
      chk({30'h0, oe7_n, oe9_n}, 32'h2);
      int_q.push_back({16'h0, k[1] ? r : r ^ MSB_FLIP});
      int_on <= 1'b1;
      pulse(1'b0, r);
      repeat (300) if (int_on) @(posedge clk);
    end
    wb(1'b1, REG_CTRL, 32'h9);
    inv <= 1'b0;
    // Read mode low must hold the word back until the conversion ends; read mode high starts shifting at once
    for (int m = 0; m < 2; m++)
    begin
      pin_in <= m[0];
      busy <= 1'b1;
      r = $urandom();
      pulse(1'b1, r);
      int_q.push_back({16'h0, r});
      int_on <= 1'b1;
      pulse(1'b0, r);
      repeat (6) @(posedge clk);
      rd(REG_STATUS, m ? 32'h15 : 32'h3);
      busy <= 1'b0;
      repeat (300) if (int_on) @(posedge clk);
    end
    // Second reset in mid-run, again with the host clocking
    link_rst();
    rd(REG_CTRL, 32'h0);
    for (int e = 0; e < 2; e++)
    begin
      inv <= e[0];
      wb(1'b1, REG_CTRL, {28'h0, ~e[0], e[0], 2'b11});
      @(posedge clk);
      chk({30'h0, oe7_n, oe9_n}, 32'h3);
      r = $urandom();
      c = $urandom();
      pin_in <= c;
      pulse(1'b1, r);
      lnk_q.push_back({12'h0, e[0] ? r ^ MSB_FLIP : r, {4{c}}});
      rreq <= 1'b1;
      @(posedge clk);
      rreq <= 1'b0;
      per <= 6'd22;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (200) if (!done) @(posedge clk);
      repeat (10) @(posedge clk);
    end
    finish_test();
  end
endmodule : adc_serial_result_port_tb
